// File: bench/fgr_fw_model.sv
// Keyboard firmware stand-in answering forwarded host writes
`timescale 1ns/1ns
module fgr_fw_model
	import fgr_pkg::*;
(
	input wire logic mclk,
	input wire logic srst,
	input wire logic kbc_wr_r,
	input wire logic kbc_cmd_r,
	input wire logic [7:0] kbc_wdata_r,
	output logic kbc_a20_output,
	output logic kbc_reset_n
);
	logic [3:0] cnt_r;
	always_ff @(posedge mclk) begin
		if (srst) begin
			cnt_r <= 4'h0;
			kbc_reset_n <= 1'b1;
			kbc_a20_output <= 1'b0;
		end else begin
			if (kbc_wr_r && kbc_cmd_r && kbc_wdata_r == 8'hFE) begin
				cnt_r <= 4'hC;
			end else if (cnt_r != 4'h0) begin
				cnt_r <= cnt_r - 4'h1;
			end
			if (kbc_wr_r && !kbc_cmd_r) begin
				kbc_a20_output <= kbc_wdata_r[1];
			end
			kbc_reset_n <= !(cnt_r != 4'h0 && cnt_r < 4'h9);
		end
	end
endmodule

// File: bench/tb.sv
// Self-checking bench for the fast A20 and alternate reset block
`timescale 1ns/1ns
`include "fgr_regs.svh"
module tb
	import fgr_pkg::*;
;
	logic mclk = 1'b0;
	logic srst = 1'b1;
	fgr_host_bus_type host = '0;
	logic cfg_wr = 1'b0;
	logic cfg_rd = 1'b0;
	logic [7:0] cfg_index = 8'h00;
	logic [7:0] cfg_wdata = 8'h00;
	logic cpu_reset_input = 1'b0;
	logic a20_polarity = 1'b0;
	logic keyboard_reset_polarity = 1'b0;
	logic kbc_a20_output, kbc_reset_n;
	logic [7:0] io_rdata_r, cfg_rdata_r, kbc_wdata_r;
	logic io_claim_r, kbc_wr_r, kbc_cmd_r, alternate_a20_r;
	logic alternate_reset_n_r, cpu_a20_mask_n_r;
	logic combined_gate_a20_r, combined_keyboard_reset_r;
	logic [31:0] seed = 32'h0000004D;
	int err_count = 0;
	int comparisons = 0;
	int dly, wid;

	fgr_top u_dut (.mclk, .srst, .host, .cfg_wr, .cfg_rd, .cfg_index,
		.cfg_wdata, .kbc_a20_output, .kbc_reset_n, .cpu_reset_input,
		.a20_polarity, .keyboard_reset_polarity, .io_rdata_r, .io_claim_r,
		.cfg_rdata_r, .kbc_wr_r, .kbc_cmd_r, .kbc_wdata_r, .alternate_a20_r,
		.alternate_reset_n_r, .cpu_a20_mask_n_r, .combined_gate_a20_r,
		.combined_keyboard_reset_r);
	fgr_fw_model u_fw (.mclk, .srst, .kbc_wr_r, .kbc_cmd_r, .kbc_wdata_r,
		.kbc_a20_output, .kbc_reset_n);

	always #50 mclk = ~mclk;

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	function automatic logic mon(input bit sel);
		return sel ? combined_keyboard_reset_r : alternate_reset_n_r;
	endfunction

	// Merged A20 from port bit, firmware bit and CPU reset
	function automatic logic exp_a20(input logic [31:0] s);
		return s[17] | s[9] | s[3];
	endfunction

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic io(input logic [15:0] a, input logic [7:0] d, input bit rd);
		@(posedge mclk);
		host <= '{a, !rd, rd, d};
		@(posedge mclk);
		host.wr <= 1'b0;
		host.rd <= 1'b0;
		#1;
	endtask

	task automatic cfg(input logic [7:0] d, input bit rd);
		@(posedge mclk);
		cfg_index <= `FGR_CFG_INDEX;
		cfg_wdata <= d;
		cfg_wr <= !rd;
		cfg_rd <= rd;
		@(posedge mclk);
		cfg_wr <= 1'b0;
		cfg_rd <= 1'b0;
		#1;
	endtask

	// Cycles until the watched reset falls, then cycles it stays low
	task automatic meas(input bit sel);
		dly = 0;
		wid = 0;
		while (mon(sel) !== 1'b0 && dly < 400) begin
			@(posedge mclk);
			#1;
			dly++;
		end
		while (mon(sel) === 1'b0 && wid < 400) begin
			@(posedge mclk);
			#1;
			wid++;
		end
	endtask

	task automatic wrap_up;
		$display("comparisons %0d errors %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		#3000000;
		err_count++;
		wrap_up;
	end

	initial begin
		repeat (12) @(posedge mclk);
		srst <= 1'b0;
		#1;
		check(alternate_a20_r, 8'h00);
		check(alternate_reset_n_r, 8'h01);
		check(combined_keyboard_reset_r, 8'h01);
		io(`FGR_P92_ADDR, 8'h03, 0);
		io(`FGR_P92_ADDR, 8'h00, 1);
		check(io_claim_r, 8'h00);
		check(alternate_a20_r, 8'h00);
		cfg(8'hFF, 0);
		cfg(8'h00, 1);
		check(cfg_rdata_r, 8'h07);
		cfg(8'h04, 0);
		io(`FGR_P92_ADDR, 8'h00, 1);
		check(io_claim_r, 8'h01);
		check(io_rdata_r, 8'h24);
		for (int i = 0; i < 24; i++) begin
			seed = xs(seed);
			@(posedge mclk);
			cpu_reset_input <= seed[3];
			a20_polarity <= seed[4];
			io(`FGR_KBC_DATA_ADDR, seed[15:8], 0);
			io(`FGR_P92_ADDR, {seed[23:17], 1'b0}, 0);
			io(`FGR_P92_ADDR, 8'h00, 1);
			check(io_rdata_r, {6'h09, seed[17], 1'b0});
			@(posedge mclk);
			#1;
			check(alternate_a20_r, seed[17]);
			check(cpu_a20_mask_n_r, exp_a20(seed));
			check(combined_gate_a20_r, exp_a20(seed) ^ seed[4]);
		end
		io(`FGR_P92_ADDR, 8'h01, 0);
		meas(1);
		check(dly >= 140 && dly < 150 && wid >= 60 && wid < 62, 8'h01);
		io(`FGR_P92_ADDR, 8'h01, 0);
		meas(0);
		check(dly >= 400, 8'h01);
		io(`FGR_P92_ADDR, 8'h00, 0);
		io(`FGR_P92_ADDR, 8'h01, 0);
		meas(0);
		check(dly >= 140 && dly < 150 && wid >= 60 && wid < 62, 8'h01);
		io(`FGR_KBC_CMD_ADDR, `FGR_CMD_PULSE_RESET, 0);
		check({kbc_wr_r, kbc_cmd_r}, 8'h03);
		check(kbc_wdata_r, `FGR_CMD_PULSE_RESET);
		meas(1);
		check(dly < 20 && wid == 8, 8'h01);
		cfg(8'h05, 0);
		io(`FGR_KBC_CMD_ADDR, `FGR_CMD_PULSE_RESET, 0);
		check(kbc_wr_r, 8'h00);
		meas(1);
		check(dly >= 140 && dly < 150 && wid >= 60 && wid < 62, 8'h01);
		@(posedge mclk);
		cpu_reset_input <= 1'b0;
		cfg(8'h06, 0);
		for (int i = 0; i < 2; i++) begin
			io(`FGR_KBC_CMD_ADDR, `FGR_CMD_WRITE_PORT, 0);
			check(kbc_wr_r, 8'h00);
			io(`FGR_KBC_DATA_ADDR, {6'h00, !i[0], 1'b1}, 0);
			check(kbc_wr_r, 8'h00);
			repeat (3) @(posedge mclk);
			#1;
			check(cpu_a20_mask_n_r, !i[0]);
			io(`FGR_KBC_CMD_ADDR, `FGR_CMD_NULL, 0);
			check(kbc_wr_r, 8'h00);
		end
		cfg(8'h07, 0);
		io(`FGR_KBC_CMD_ADDR, `FGR_CMD_WRITE_PORT, 0);
		io(`FGR_KBC_DATA_ADDR, 8'h00, 0);
		repeat (3) @(posedge mclk);
		#1;
		check(combined_keyboard_reset_r, 8'h00);
		check(cpu_a20_mask_n_r, 8'h00);
		cfg(8'h06, 0);
		@(posedge mclk);
		keyboard_reset_polarity <= 1'b1;
		repeat (3) @(posedge mclk);
		#1;
		check(combined_keyboard_reset_r, 8'h00);
		wrap_up;
	end
endmodule

// File: rtl/fgr_pkg.sv
// Types shared by the fast A20 and alternate reset block
package fgr_pkg;

	typedef struct packed {
		logic [15:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} fgr_host_bus_type;

	typedef enum logic [1:0] {PS_IDLE, PS_WAIT, PS_LOW} fgr_pulse_state_type;

	typedef struct packed {
		fgr_pulse_state_type state;
		logic [7:0] cnt;
		logic out_n;
	} fgr_pulse_st_type;

	typedef enum logic {KS_IDLE, KS_WAIT_DATA} fgr_kbc_state_type;

	typedef struct packed {
		logic [2:0] cfg;
		logic port_a20;
		logic port_rst;
		fgr_kbc_state_type ks;
		logic hw_a20;
		logic hw_rst;
		logic [7:0] rdata;
		logic claim;
		logic [7:0] cfg_rdata;
		logic kbc_wr;
		logic kbc_cmd;
		logic [7:0] kbc_wdata;
		logic p92_start;
		logic kb_start;
		logic alternate_a20;
		logic alt_rst_n;
		logic a20_mask_n;
		logic gate_a20;
		logic kb_rst;
	} fgr_top_st_type;

endpackage

// File: rtl/fgr_pulse.sv
// Delayed active-low reset pulse generator
`timescale 1ns/1ns
`include "fgr_regs.svh"
module fgr_pulse
	import fgr_pkg::*;
(
	input wire logic mclk,
	input wire logic srst,
	input wire logic start,
	output logic pulse_n_r
);

	fgr_pulse_st_type st_r;
	fgr_pulse_st_type st_nxt;

	always_comb begin
		st_nxt = st_r;
		case (st_r.state)
		PS_IDLE: begin
			if (start) begin
				st_nxt.state = PS_WAIT;
				st_nxt.cnt = 8'h00;
			end
		end
		PS_WAIT: begin
			if (st_r.cnt == 8'(`FGR_DLY_CYC - 1)) begin
				st_nxt.state = PS_LOW;
				st_nxt.cnt = 8'h00;
			end else begin
				st_nxt.cnt = st_r.cnt + 8'h01;
			end
		end
		PS_LOW: begin
			if (st_r.cnt == 8'(`FGR_LOW_CYC - 1)) begin
				st_nxt.state = PS_IDLE;
			end else begin
				st_nxt.cnt = st_r.cnt + 8'h01;
			end
		end
		default: begin
			st_nxt.state = PS_IDLE;
		end
		endcase
		st_nxt.out_n = (st_nxt.state != PS_LOW);
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			st_r <= '{state: PS_IDLE, cnt: 8'h00, out_n: 1'b1};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign pulse_n_r = st_r.out_n;

	AST_PULSE_DELAY: assert property (@(posedge mclk) disable iff (srst)
		(start && st_r.state == PS_IDLE) |-> ##140 pulse_n_r ##1 !pulse_n_r)
		else $error("Reset pulse delay wrong");
	AST_PULSE_WIDTH: assert property (@(posedge mclk) disable iff (srst)
		$fell(pulse_n_r) |-> ##59 !pulse_n_r ##1 pulse_n_r)
		else $error("Reset pulse width wrong");

endmodule

// File: rtl/fgr_regs.svh
// Offsets, field positions, reset values and timing for the fast A20 block
`ifndef FGR_REGS_SVH
`define FGR_REGS_SVH

`define FGR_P92_ADDR 16'h0092
`define FGR_KBC_DATA_ADDR 16'h0060
`define FGR_KBC_CMD_ADDR 16'h0064
`define FGR_CFG_INDEX 8'hF0

`define FGR_CFG_P92EN 2
`define FGR_CFG_A20HW 1
`define FGR_CFG_RSTHW 0
`define FGR_CFG_RESET 3'h0

`define FGR_P92_A20 1
`define FGR_P92_RST 0
`define FGR_P92_RESET 8'h24
`define FGR_P92_FIXED 6'h09

`define FGR_CMD_WRITE_PORT 8'hD1
`define FGR_CMD_PULSE_RESET 8'hFE
`define FGR_CMD_NULL 8'hFF

`define FGR_CLK_NS 100
`define FGR_DLY_NS 14000
`define FGR_LOW_NS 6000
`define FGR_DLY_CYC ((`FGR_DLY_NS + `FGR_CLK_NS - 1) / `FGR_CLK_NS)
`define FGR_LOW_CYC ((`FGR_LOW_NS + `FGR_CLK_NS - 1) / `FGR_CLK_NS)

`endif

// File: rtl/fgr_top.sv
// Fast A20 port, alternate reset and keyboard reset/A20 merge
// Functional notes
// - Port 92h usable only when enabled
// - Port read shows fixed pattern 0010_01xx
// - Bit 1 write sets alternate A20 level
// - Bit 0 read/write, cleared by reset
// - Reset pulse low 6us after 14us
// - No new pulse until bit 0 cleared
// - Reset leaves alternate reset high
// - A20 mask is OR of sources
// - Reset drives alternate A20 low
// - Firmware mode: FE goes to firmware
// - Speed-up mode: FE pulses in hardware
// - Port pulse ANDed into keyboard reset
// - Config bits: enable, A20, reset select
// - D1 then data latches A20, reset
// - Output polarity follows pin polarity bit
`timescale 1ns/1ns
`include "fgr_regs.svh"
module fgr_top
	import fgr_pkg::*;
(
	input wire logic mclk,
	input wire logic srst,
	input wire fgr_host_bus_type host,
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire logic [7:0] cfg_index,
	input wire logic [7:0] cfg_wdata,
	input wire logic kbc_a20_output,
	input wire logic kbc_reset_n,
	input wire logic cpu_reset_input,
	input wire logic a20_polarity,
	input wire logic keyboard_reset_polarity,
	output logic [7:0] io_rdata_r,
	output logic io_claim_r,
	output logic [7:0] cfg_rdata_r,
	output logic kbc_wr_r,
	output logic kbc_cmd_r,
	output logic [7:0] kbc_wdata_r,
	output logic alternate_a20_r,
	output logic alternate_reset_n_r,
	output logic cpu_a20_mask_n_r,
	output logic combined_gate_a20_r,
	output logic combined_keyboard_reset_r
);

	fgr_top_st_type st_r;
	fgr_top_st_type st_nxt;
	logic alt_pulse_n;
	logic kb_pulse_n;
	logic p92_en;
	logic a20_hw;
	logic rst_hw;
	logic wr92;
	logic rd92;
	logic wr60;
	logic wr64;
	logic merged_a20;
	logic merged_rst_n;

	// Host address match
	function automatic logic io_hit(input fgr_host_bus_type b,
		input logic [15:0] a);
		io_hit = (b.addr == a);
	endfunction

	// Port 92h read image
	function automatic logic [7:0] p92_image(input logic a20,
		input logic rst);
		p92_image = {`FGR_P92_FIXED, a20, rst};
	endfunction

	fgr_pulse u_alt_pulse (
		.mclk(mclk),
		.srst(srst),
		.start(st_r.p92_start),
		.pulse_n_r(alt_pulse_n)
	);

	fgr_pulse u_kb_pulse (
		.mclk(mclk),
		.srst(srst),
		.start(st_r.kb_start),
		.pulse_n_r(kb_pulse_n)
	);

	// Configuration fields
	assign p92_en = st_r.cfg[`FGR_CFG_P92EN];
	assign a20_hw = st_r.cfg[`FGR_CFG_A20HW];
	assign rst_hw = st_r.cfg[`FGR_CFG_RSTHW];

	// Host cycle decode
	assign wr92 = host.wr && io_hit(host, `FGR_P92_ADDR) && p92_en;
	assign rd92 = host.rd && io_hit(host, `FGR_P92_ADDR) && p92_en;
	assign wr60 = host.wr && io_hit(host, `FGR_KBC_DATA_ADDR);
	assign wr64 = host.wr && io_hit(host, `FGR_KBC_CMD_ADDR);

	always_comb begin
		st_nxt = st_r;
		st_nxt.rdata = 8'h00;
		st_nxt.claim = 1'b0;
		st_nxt.cfg_rdata = 8'h00;
		st_nxt.kbc_wr = 1'b0;
		st_nxt.kbc_cmd = 1'b0;
		st_nxt.kbc_wdata = 8'h00;
		st_nxt.p92_start = 1'b0;
		st_nxt.kb_start = 1'b0;

		// Configuration register
		if (cfg_wr && cfg_index == `FGR_CFG_INDEX) begin
			st_nxt.cfg = cfg_wdata[2:0];
		end
		if (cfg_rd && cfg_index == `FGR_CFG_INDEX) begin
			st_nxt.cfg_rdata = {5'h00, st_r.cfg};
		end

		// Port 92h
		if (wr92) begin
			st_nxt.port_a20 = host.wdata[`FGR_P92_A20];
			st_nxt.port_rst = host.wdata[`FGR_P92_RST];
			st_nxt.p92_start = host.wdata[`FGR_P92_RST] &&
				!st_r.port_rst;
		end
		if (rd92) begin
			st_nxt.rdata = p92_image(st_r.port_a20, st_r.port_rst);
			st_nxt.claim = 1'b1;
		end

		// Keyboard command and data writes
		if (wr64) begin
			st_nxt.ks = KS_IDLE;
			if (a20_hw && host.wdata == `FGR_CMD_WRITE_PORT) begin
				st_nxt.ks = KS_WAIT_DATA;
			end else if (a20_hw && host.wdata == `FGR_CMD_NULL &&
				st_r.ks == KS_IDLE) begin
				st_nxt.ks = KS_IDLE;
			end else if (rst_hw &&
				host.wdata == `FGR_CMD_PULSE_RESET) begin
				st_nxt.kb_start = 1'b1;
			end else begin
				st_nxt.kbc_wr = 1'b1;
				st_nxt.kbc_cmd = 1'b1;
				st_nxt.kbc_wdata = host.wdata;
			end
		end else if (wr60) begin
			if (st_r.ks == KS_WAIT_DATA && a20_hw) begin
				st_nxt.hw_a20 = host.wdata[1];
				st_nxt.hw_rst = host.wdata[0];
				st_nxt.ks = KS_IDLE;
			end else begin
				st_nxt.kbc_wr = 1'b1;
				st_nxt.kbc_wdata = host.wdata;
				st_nxt.ks = KS_IDLE;
			end
		end

		// A20 merge
		merged_a20 = (a20_hw ? st_r.hw_a20 : kbc_a20_output) |
			(p92_en & st_r.port_a20) | cpu_reset_input;
		st_nxt.a20_mask_n = merged_a20;
		st_nxt.gate_a20 = merged_a20 ^ a20_polarity;
		st_nxt.alternate_a20 = st_r.port_a20;

		// Keyboard reset merge
		merged_rst_n = (rst_hw ? (kb_pulse_n & st_r.hw_rst) : kbc_reset_n)
			& (p92_en ? alt_pulse_n : 1'b1);
		st_nxt.kb_rst = merged_rst_n ^ keyboard_reset_polarity;
		st_nxt.alt_rst_n = alt_pulse_n;
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			st_r <= '{
				cfg: `FGR_CFG_RESET,
				port_a20: 1'b0,
				port_rst: 1'b0,
				ks: KS_IDLE,
				hw_a20: 1'b0,
				hw_rst: 1'b1,
				rdata: 8'h00,
				claim: 1'b0,
				cfg_rdata: 8'h00,
				kbc_wr: 1'b0,
				kbc_cmd: 1'b0,
				kbc_wdata: 8'h00,
				p92_start: 1'b0,
				kb_start: 1'b0,
				alternate_a20: 1'b0,
				alt_rst_n: 1'b1,
				a20_mask_n: 1'b0,
				gate_a20: 1'b0,
				kb_rst: 1'b1
			};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign io_rdata_r = st_r.rdata;
	assign io_claim_r = st_r.claim;
	assign cfg_rdata_r = st_r.cfg_rdata;
	assign kbc_wr_r = st_r.kbc_wr;
	assign kbc_cmd_r = st_r.kbc_cmd;
	assign kbc_wdata_r = st_r.kbc_wdata;
	assign alternate_a20_r = st_r.alternate_a20;
	assign alternate_reset_n_r = st_r.alt_rst_n;
	assign cpu_a20_mask_n_r = st_r.a20_mask_n;
	assign combined_gate_a20_r = st_r.gate_a20;
	assign combined_keyboard_reset_r = st_r.kb_rst;

	AST_DISABLED_WRITE: assert property (@(posedge mclk) disable iff (srst)
		(host.wr && io_hit(host, `FGR_P92_ADDR) && !p92_en) |=>
		$stable({st_r.port_a20, st_r.port_rst}))
		else $error("Disabled port changed");
	AST_DISABLED_READ: assert property (@(posedge mclk) disable iff (srst)
		(host.rd && !p92_en) |=> !io_claim_r)
		else $error("Disabled port claimed read");
	AST_READ_IMAGE: assert property (@(posedge mclk) disable iff (srst)
		rd92 |=> io_claim_r && io_rdata_r[7:2] == 6'h09)
		else $error("Port read image wrong");
	AST_A20_WRITE: assert property (@(posedge mclk) disable iff (srst)
		wr92 |-> ##2 alternate_a20_r == $past(host.wdata[1], 2))
		else $error("Alternate A20 not following write");
	AST_RESET_STATE: assert property (@(posedge mclk)
		srst |=> alternate_reset_n_r && !alternate_a20_r &&
		!st_r.port_rst)
		else $error("Reset state wrong");
	AST_ONE_SHOT: assert property (@(posedge mclk) disable iff (srst)
		(wr92 && st_r.port_rst) |=> !st_r.p92_start)
		else $error("Pulse restarted without clear");
	AST_P92_START: assert property (@(posedge mclk) disable iff (srst)
		(wr92 && !st_r.port_rst && host.wdata[0]) |=> st_r.p92_start)
		else $error("Pulse not started");
	AST_A20_OR: assert property (@(posedge mclk) disable iff (srst)
		(p92_en && st_r.port_a20) |=> cpu_a20_mask_n_r)
		else $error("A20 mask not forced high");
	AST_D1_SWALLOW: assert property (@(posedge mclk) disable iff (srst)
		(wr64 && a20_hw && host.wdata == `FGR_CMD_WRITE_PORT) |=>
		!kbc_wr_r && st_r.ks == KS_WAIT_DATA)
		else $error("D1 reached firmware");
	AST_FE_HW: assert property (@(posedge mclk) disable iff (srst)
		(wr64 && rst_hw && !a20_hw &&
		host.wdata == `FGR_CMD_PULSE_RESET) |=> st_r.kb_start && !kbc_wr_r)
		else $error("FE not handled in hardware");
	AST_FE_FW: assert property (@(posedge mclk) disable iff (srst)
		(wr64 && !rst_hw && !a20_hw) |=> kbc_wr_r && kbc_cmd_r)
		else $error("Command not forwarded");
	AST_RST_AND: assert property (@(posedge mclk) disable iff (srst)
		(p92_en && !alt_pulse_n) |=>
		combined_keyboard_reset_r == $past(keyboard_reset_polarity))
		else $error("Port pulse not merged");
	AST_CFG_WRITE: assert property (@(posedge mclk) disable iff (srst)
		(cfg_wr && cfg_index == `FGR_CFG_INDEX) |=>
		st_r.cfg == $past(cfg_wdata[2:0]))
		else $error("Config write not stored");
	AST_CFG_READ: assert property (@(posedge mclk) disable iff (srst)
		(cfg_rd && cfg_index == `FGR_CFG_INDEX) |=>
		cfg_rdata_r == {5'h00, $past(st_r.cfg)})
		else $error("Config read data wrong");
	AST_IDLE_BUS: assert property (@(posedge mclk) disable iff (srst)
		!rd92 |=> !io_claim_r && io_rdata_r == 8'h00)
		else $error("Port read data without claim");
	AST_RST_BIT: assert property (@(posedge mclk) disable iff (srst)
		wr92 |=> st_r.port_rst == $past(host.wdata[`FGR_P92_RST]))
		else $error("Reset bit not stored");
	AST_FW_DATA: assert property (@(posedge mclk) disable iff (srst)
		(wr64 && !a20_hw && !rst_hw) |=>
		kbc_wdata_r == $past(host.wdata))
		else $error("Forwarded command data wrong");
	AST_DATA_FWD: assert property (@(posedge mclk) disable iff (srst)
		(wr60 && !(a20_hw && st_r.ks == KS_WAIT_DATA)) |=>
		kbc_wr_r && !kbc_cmd_r && kbc_wdata_r == $past(host.wdata))
		else $error("Data write not forwarded");
	AST_D1_DATA: assert property (@(posedge mclk) disable iff (srst)
		(wr60 && a20_hw && st_r.ks == KS_WAIT_DATA) |=> !kbc_wr_r &&
		st_r.hw_a20 == $past(host.wdata[1]) &&
		st_r.hw_rst == $past(host.wdata[0]))
		else $error("D1 data not latched");
	AST_FF_SWALLOW: assert property (@(posedge mclk) disable iff (srst)
		(wr64 && a20_hw && host.wdata == `FGR_CMD_NULL &&
		st_r.ks == KS_IDLE) |=> !kbc_wr_r)
		else $error("Null command reached firmware");
	AST_A20_HW: assert property (@(posedge mclk) disable iff (srst)
		(a20_hw && st_r.hw_a20) |=> cpu_a20_mask_n_r)
		else $error("Latched A20 not applied");
	AST_A20_LOW: assert property (@(posedge mclk) disable iff (srst)
		(!(a20_hw ? st_r.hw_a20 : kbc_a20_output) && !cpu_reset_input &&
		!(p92_en && st_r.port_a20)) |=> !cpu_a20_mask_n_r)
		else $error("A20 mask high with no source");
	AST_GATE_POL: assert property (@(posedge mclk) disable iff (srst)
		!$past(srst) |-> combined_gate_a20_r ==
		(cpu_a20_mask_n_r ^ $past(a20_polarity)))
		else $error("Gate A20 polarity wrong");
	AST_KRST_FW: assert property (@(posedge mclk) disable iff (srst)
		(!rst_hw && !p92_en) |=> combined_keyboard_reset_r ==
		($past(kbc_reset_n) ^ $past(keyboard_reset_polarity)))
		else $error("Firmware reset not passed");
	AST_KRST_HW: assert property (@(posedge mclk) disable iff (srst)
		(rst_hw && !kb_pulse_n) |=>
		combined_keyboard_reset_r == $past(keyboard_reset_polarity))
		else $error("Hardware reset pulse not passed");
	AST_ALT_COPY: assert property (@(posedge mclk) disable iff (srst)
		!$past(srst) |-> alternate_reset_n_r == $past(alt_pulse_n))
		else $error("Alternate reset not following pulse");

endmodule
